// ---- design/gpcfg_top.sv ----
// Behaviour
// - bit 0 of a pin configuration register makes the pin an input when 1 and a driven output when 0, except pin 4.1 in edge interrupt mode.
// - on every pin but 4.2, bit 1 inverts the pin value between the pin and its internal function or register when 1.
// - on every pin but 4.2, bit 7 makes the output open-drain (drives only low) when 1 and push-pull when 0.
// - on pins 3.6, 3.7 and 4.0 bit 2 picks keyboard reset, address-20 gate or density select 0.
// - on pin 4.1 bits 3:2 pick plain GPIO, density select 1, edge interrupt 2, or reserved.
// - with pin 4.1 in edge interrupt mode, both rising and falling pin edges raise interrupt 2.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "gpcfg_map.svh"
module gpcfg_top #(
	parameter int NPINS = 5
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic [NPINS-1:0] PIN_IN,
	output logic [NPINS-1:0] PIN_OUT,
	output logic [NPINS-1:0] PIN_OE_N,
	input wire logic ALT_KEYBOARD_RESET_OUT,
	input wire logic ALT_ADDRESS20_GATE,
	input wire logic ALT_DRIVE_DENSITY_SEL_0,
	input wire logic ALT_DRIVE_DENSITY_SEL_1,
	output logic EDGE_INT2,
	output logic IRQ
);
	// ==========================================================
	// decode helpers
	// slot 0..4 are the pin configuration registers, 7 means none
	function automatic logic [2:0] slot_of(input logic [6:0] idx);
		case (idx)
			`GPCFG_IDX_P36: slot_of = 3'h0;
			`GPCFG_IDX_P37: slot_of = 3'h1;
			`GPCFG_IDX_P40: slot_of = 3'h2;
			`GPCFG_IDX_P41: slot_of = 3'h3;
			`GPCFG_IDX_P42: slot_of = 3'h4;
			default: slot_of = 3'h7;
		endcase
	endfunction : slot_of

	function automatic logic [7:0] wmask_of(input logic [2:0] slot);
		case (slot)
			3'h3: wmask_of = `GPCFG_WMASK_P41;
			3'h4: wmask_of = `GPCFG_WMASK_P42;
			default: wmask_of = `GPCFG_WMASK_STD;
		endcase
	endfunction : wmask_of

	// ==========================================================
	// register storage
	logic [7:0] cfg_q [0:NPINS-1];
	logic [5:0] status_q;
	logic [5:0] mask_q;
	logic [NPINS-1:0] outd_q;
	gpcfg_pkg::gpcfg_cfg_s cfg_s [0:NPINS-1];
	gpcfg_pkg::gpcfg_fn41_e fn41;

	// ==========================================================
	// bus slave state
	gpcfg_pkg::gpcfg_bus_e bus_q;
	gpcfg_pkg::gpcfg_aphase_s aph_q;
	logic hready_q;
	logic [31:0] hrdata_q;
	logic hresp_q;
	logic take;
	logic addr_ok;
	logic wr_en;
	logic [2:0] wr_slot;
	logic [7:0] wdat;

	// ==========================================================
	// pin side
	logic [NPINS-1:0] sync1_q;
	logic [NPINS-1:0] sync2_q;
	logic [NPINS-1:0] prev_q;
	logic [1:0] warm_q;
	logic [NPINS-1:0] edge_seen;
	logic [NPINS-1:0] invert_v;
	logic [NPINS-1:0] dir_v;
	logic [NPINS-1:0] level_v;
	logic [NPINS-1:0] alt_sel;
	logic [NPINS-1:0] alt_val;
	logic [NPINS-1:0] input_only;
	gpcfg_pkg::gpcfg_drive_s drive [0:NPINS-1];
	logic [NPINS-1:0] pin_out_q;
	logic [NPINS-1:0] pin_oe_n_q;
	logic [5:0] evt_set;
	logic int2_edge;
	logic int2_q;
	logic irq_q;

	// ==========================================================
	// address phase capture
	// only the low nine address bits decode; anything above must be zero
	assign addr_ok = (HADDR[31:9] == 23'h000000) && (HADDR[1:0] == 2'h0);
	assign take = HSEL && HREADY && HTRANS[1];

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			aph_q <= '0;
		end else if (take) begin
			aph_q.write <= HWRITE;
			aph_q.idx <= addr_ok ? HADDR[8:2] : 7'h00;
		end
	end

	// reads take one wait state so read data always comes from a flop
	// and a write in the preceding data phase is already visible
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			bus_q <= gpcfg_pkg::BUS_IDLE;
		end else begin
			case (bus_q)
				gpcfg_pkg::BUS_READ_WAIT: begin
					bus_q <= gpcfg_pkg::BUS_READ_DONE;
				end
				gpcfg_pkg::BUS_IDLE, gpcfg_pkg::BUS_WRITE, gpcfg_pkg::BUS_READ_DONE: begin
					if (take && HWRITE) begin
						bus_q <= gpcfg_pkg::BUS_WRITE;
					end else if (take) begin
						bus_q <= gpcfg_pkg::BUS_READ_WAIT;
					end else begin
						bus_q <= gpcfg_pkg::BUS_IDLE;
					end
				end
				default: begin
					bus_q <= gpcfg_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			hready_q <= 1'b1;
		end else if (bus_q == gpcfg_pkg::BUS_READ_WAIT) begin
			hready_q <= 1'b1;
		end else begin
			hready_q <= !(take && !HWRITE);
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			hresp_q <= 1'b0;
		end else begin
			hresp_q <= 1'b0;
		end
	end

	// unmapped reads return zero
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			hrdata_q <= 32'h00000000;
		end else if (bus_q == gpcfg_pkg::BUS_READ_WAIT) begin
			hrdata_q <= 32'h00000000;
			case (aph_q.idx)
				`GPCFG_IDX_STATUS: hrdata_q[5:0] <= status_q;
				`GPCFG_IDX_MASK: hrdata_q[5:0] <= mask_q;
				`GPCFG_IDX_LEVEL: hrdata_q[NPINS-1:0] <= level_v;
				`GPCFG_IDX_OUTD: hrdata_q[NPINS-1:0] <= outd_q;
				default: begin
					if (slot_of(aph_q.idx) != 3'h7) begin
						hrdata_q[7:0] <= cfg_q[slot_of(aph_q.idx)];
					end
				end
			endcase
		end
	end

	assign wr_en = (bus_q == gpcfg_pkg::BUS_WRITE);
	assign wr_slot = slot_of(aph_q.idx);
	assign wdat = HWDATA[7:0];

	// ==========================================================
	// configuration registers
	generate
		for (genvar i = 0; i < NPINS; i++) begin : g_cfg
			always_ff @(posedge SYS_CLK or negedge RST_N) begin
				if (!RST_N) begin
					cfg_q[i] <= (i == 4) ? `GPCFG_P42_RST : `GPCFG_CFG_RST;
				end else if (wr_en && wr_slot == 3'(i)) begin
					cfg_q[i] <= wdat & wmask_of(3'(i));
				end
			end
			assign cfg_s[i] = gpcfg_pkg::gpcfg_cfg_s'(cfg_q[i]);
			assign invert_v[i] = cfg_s[i].invert;
			assign dir_v[i] = cfg_s[i].input_dir;
		end
	endgenerate

	assign fn41 = gpcfg_pkg::gpcfg_fn41_e'({cfg_s[3].alt_hi, cfg_s[3].alt_lo});

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			outd_q <= `GPCFG_OUTD_RST;
		end else if (wr_en && aph_q.idx == `GPCFG_IDX_OUTD) begin
			outd_q <= HWDATA[NPINS-1:0];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mask_q <= `GPCFG_EVT_RST;
		end else if (wr_en && aph_q.idx == `GPCFG_IDX_MASK) begin
			mask_q <= HWDATA[5:0];
		end
	end

	// ==========================================================
	// pin input synchronisers and edge detect
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q <= '0;
			warm_q <= 2'h0;
		end else begin
			sync1_q <= PIN_IN;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
			if (warm_q != `GPCFG_SYNC_FILL) begin
				warm_q <= warm_q + 2'h1;
			end
		end
	end

	// the pipeline starts at zero whatever the pins idle at, so edges are
	// ignored until it holds real samples; otherwise reset fakes an event
	assign edge_seen = (sync2_q ^ prev_q) & {NPINS{warm_q == `GPCFG_SYNC_FILL}};
	assign level_v = sync2_q ^ invert_v;

	// both directions count, the edge detector ignores polarity
	assign int2_edge = edge_seen[3] && (fn41 == gpcfg_pkg::FN41_EDGE_INT);
	assign evt_set = {int2_edge, edge_seen & dir_v};

	// ==========================================================
	// event status and interrupt
	// a new event in the clearing cycle survives the clear
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			status_q <= `GPCFG_EVT_RST;
		end else if (wr_en && aph_q.idx == `GPCFG_IDX_STATUS) begin
			status_q <= (status_q & ~HWDATA[5:0]) | evt_set;
		end else begin
			status_q <= status_q | evt_set;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			int2_q <= 1'b0;
		end else begin
			int2_q <= int2_edge;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_q & mask_q);
		end
	end

	// ==========================================================
	// alternate function routing
	assign alt_sel[0] = cfg_s[0].alt_lo;
	assign alt_sel[1] = cfg_s[1].alt_lo;
	assign alt_sel[2] = cfg_s[2].alt_lo;
	assign alt_sel[3] = (fn41 == gpcfg_pkg::FN41_DENSITY);
	assign alt_sel[4] = 1'b0;
	assign alt_val = {1'b0, ALT_DRIVE_DENSITY_SEL_1, ALT_DRIVE_DENSITY_SEL_0,
		ALT_ADDRESS20_GATE, ALT_KEYBOARD_RESET_OUT};
	// the edge interrupt is a pure input, so the driver is kept off
	assign input_only = {1'b0, fn41 == gpcfg_pkg::FN41_EDGE_INT, 3'b000};

	generate
		for (genvar i = 0; i < NPINS; i++) begin : g_pin
			gpcfg_pin u_pin (
				.cfg(cfg_s[i]),
				.gpio_data(outd_q[i]),
				.alt_sel(alt_sel[i]),
				.alt_val(alt_val[i]),
				.input_only(input_only[i]),
				.drive(drive[i])
			);
			always_ff @(posedge SYS_CLK or negedge RST_N) begin
				if (!RST_N) begin
					pin_out_q[i] <= 1'b0;
					pin_oe_n_q[i] <= 1'b1;
				end else begin
					pin_out_q[i] <= drive[i].level;
					pin_oe_n_q[i] <= drive[i].release_n;
				end
			end
		end
	endgenerate

	// ==========================================================
	// outputs
	assign HRDATA = hrdata_q;
	assign HREADYOUT = hready_q;
	assign HRESP = hresp_q;
	assign PIN_OUT = pin_out_q;
	assign PIN_OE_N = pin_oe_n_q;
	assign EDGE_INT2 = int2_q;
	assign IRQ = irq_q;

	// ==========================================================
	// checks
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);

	dir_input_off_a: assert property (cfg_s[0].input_dir |=> PIN_OE_N[0])
		else $error("pin configured as input is still driven");

	pol_push_pull_a: assert property (
		(!cfg_s[2].input_dir && !cfg_s[2].open_drain && !cfg_s[2].alt_lo)
		|=> (PIN_OUT[2] == ($past(outd_q[2]) ^ $past(cfg_s[2].invert))) && !PIN_OE_N[2])
		else $error("push-pull gpio level or polarity wrong");

	open_drain_low_a: assert property (
		(!cfg_s[1].input_dir && cfg_s[1].open_drain) |=> !PIN_OUT[1])
		else $error("open-drain pin drove a high level");

	kbd_alt_route_a: assert property (
		(!cfg_s[0].input_dir && !cfg_s[0].open_drain && cfg_s[0].alt_lo)
		|=> PIN_OUT[0] == ($past(ALT_KEYBOARD_RESET_OUT) ^ $past(cfg_s[0].invert)))
		else $error("keyboard reset not routed to its pin");

	density1_route_a: assert property (
		(fn41 == gpcfg_pkg::FN41_DENSITY && !cfg_s[3].input_dir && !cfg_s[3].open_drain)
		|=> PIN_OUT[3] == ($past(ALT_DRIVE_DENSITY_SEL_1) ^ $past(cfg_s[3].invert)))
		else $error("density select 1 not routed to its pin");

	int2_edge_a: assert property (
		(fn41 == gpcfg_pkg::FN41_EDGE_INT && $changed(sync2_q[3]))
		|=> EDGE_INT2 && status_q[`GPCFG_ST_INT2] ##1 PIN_OE_N[3])
		else $error("pin edge did not raise interrupt 2");

	rsvd_zero_a: assert property (
		cfg_q[0][6:3] == 4'h0 && cfg_q[3][6:4] == 3'h0 && cfg_q[4][7:1] == 7'h00)
		else $error("reserved configuration bits became set");

	read_wait_a: assert property (
		(take && !HWRITE) |=> !HREADYOUT ##1 HREADYOUT)
		else $error("read did not take exactly one wait state");

	int2_cov_c: cover property (fn41 == gpcfg_pkg::FN41_EDGE_INT ##1 EDGE_INT2 ##[1:4] IRQ);
	read_cov_c: cover property (bus_q == gpcfg_pkg::BUS_READ_DONE && aph_q.idx == `GPCFG_IDX_P41);
	od_cov_c: cover property (cfg_s[1].open_drain && !cfg_s[1].input_dir && !PIN_OE_N[1]);
endmodule : gpcfg_top

// ---- design/gpcfg_map.svh ----
`ifndef GPCFG_MAP_SVH
`define GPCFG_MAP_SVH
// register indices; byte address is four times the index
`define GPCFG_IDX_P36 7'h39
`define GPCFG_IDX_P37 7'h3a
`define GPCFG_IDX_P40 7'h3b
`define GPCFG_IDX_P41 7'h3c
`define GPCFG_IDX_P42 7'h3d
`define GPCFG_IDX_STATUS 7'h3e
`define GPCFG_IDX_MASK 7'h3f
`define GPCFG_IDX_LEVEL 7'h40
`define GPCFG_IDX_OUTD 7'h41
// reset values
`define GPCFG_CFG_RST 8'h01
`define GPCFG_P42_RST 8'h01
`define GPCFG_EVT_RST 6'h00
`define GPCFG_OUTD_RST 5'h00
// edges before the input pipeline holds real pin samples are ignored
`define GPCFG_SYNC_FILL 2'h3
// field positions
`define GPCFG_BIT_DIR 0
`define GPCFG_BIT_INV 1
`define GPCFG_BIT_ALT 2
`define GPCFG_BIT_OD 7
`define GPCFG_ST_INT2 5
// writable bits per register flavour
`define GPCFG_WMASK_STD 8'h87
`define GPCFG_WMASK_P41 8'h8f
`define GPCFG_WMASK_P42 8'h01
`endif

// ---- design/gpcfg_pkg.sv ----
package gpcfg_pkg;
	typedef struct packed {
		logic open_drain;
		logic [2:0] rsvd;
		logic alt_hi;
		logic alt_lo;
		logic invert;
		logic input_dir;
	} gpcfg_cfg_s;
	typedef enum logic [1:0] {FN41_GPIO, FN41_DENSITY, FN41_EDGE_INT, FN41_RSVD} gpcfg_fn41_e;
	typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ_WAIT, BUS_READ_DONE} gpcfg_bus_e;
	typedef struct packed {
		logic write;
		logic [6:0] idx;
	} gpcfg_aphase_s;
	typedef struct packed {
		logic release_n;
		logic level;
	} gpcfg_drive_s;
endpackage : gpcfg_pkg

// ---- design/gpcfg_pin.sv ----
`timescale 1ns/1ps
module gpcfg_pin (
	input wire gpcfg_pkg::gpcfg_cfg_s cfg,
	input wire logic gpio_data,
	input wire logic alt_sel,
	input wire logic alt_val,
	input wire logic input_only,
	output gpcfg_pkg::gpcfg_drive_s drive
);
	logic value;
	always_comb begin
		value = (alt_sel ? alt_val : gpio_data) ^ cfg.invert;
		drive.release_n = 1'b1;
		drive.level = 1'b0;
		if (cfg.input_dir || input_only) begin
			drive.release_n = 1'b1;
			drive.level = 1'b0;
		end else if (cfg.open_drain) begin
			drive.release_n = value;
			drive.level = 1'b0;
		end else begin
			drive.release_n = 1'b0;
			drive.level = value;
		end
	end
endmodule : gpcfg_pin

// ---- testbench/gpcfg_board.sv ----
`timescale 1ns/1ps
// ==========
// board wiring
module gpcfg_board (
	input wire logic [4:0] pin_out,
	input wire logic [4:0] pin_oe_n,
	input wire logic [4:0] ext_en,
	input wire logic [4:0] ext_lvl,
	output logic [4:0] pin_w
);
	// released, undriven lines sit at the pull-up that open-drain use needs
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			if (!pin_oe_n[i])
				pin_w[i] = pin_out[i];
			else if (ext_en[i])
				pin_w[i] = ext_lvl[i];
			else
				pin_w[i] = 1'b1;
		end
	end
endmodule : gpcfg_board

// ---- testbench/gpcfg_top_tb.sv ----
`timescale 1ns/1ps
`include "gpcfg_map.svh"
module gpcfg_top_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [3:0] alt = 4'h0;
	logic [4:0] ext_en = 5'h00;
	logic [4:0] ext_lvl = 5'h00;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [4:0] pin_out;
	logic [4:0] pin_oe_n;
	logic [4:0] pin_w;
	logic edge_int2;
	logic irq;
	logic [31:0] r;
	logic [7:0] m;
	int num_errors = 0;
	int n_tests = 0;
	int seed = 32'h09dba29d;
	always #4 clk = ~clk;
	gpcfg_top dut_u (.SYS_CLK(clk), .RST_N(rst_n), .HSEL(1'b1), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
		.PIN_IN(pin_w), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n),
		.ALT_KEYBOARD_RESET_OUT(alt[0]), .ALT_ADDRESS20_GATE(alt[1]),
		.ALT_DRIVE_DENSITY_SEL_0(alt[2]), .ALT_DRIVE_DENSITY_SEL_1(alt[3]),
		.EDGE_INT2(edge_int2), .IRQ(irq));
	gpcfg_board board_u (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en),
		.ext_lvl(ext_lvl), .pin_w(pin_w));
	// ==========
	// bus and compare tasks
	task summarize;
		if (num_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// writable bits of each configuration register
	function automatic logic [31:0] cfg_exp(input int i, input logic [31:0] v);
		if (i == 4)
			return v & `GPCFG_WMASK_P42;
		else if (i == 3)
			return v & `GPCFG_WMASK_P41;
		return v & `GPCFG_WMASK_STD;
	endfunction : cfg_exp
	task rdy;
		int k;
		k = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1 && k < 16) begin
			@(posedge clk);
			k++;
		end
		if (hreadyout !== 1'b1) begin
			num_errors++;
			summarize;
		end
	endtask : rdy
	task bus(input logic [6:0] i, input logic w, input logic [31:0] dv, output logic [31:0] q);
		@(posedge clk);
		haddr <= {23'h0, i, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		rdy;
		htrans <= 2'b00;
		hwdata <= dv;
		rdy;
		q = hrdata;
	endtask : bus
	task wr(input logic [6:0] i, input logic [31:0] dv);
		logic [31:0] q;
		bus(i, 1'b1, dv, q);
	endtask : wr
	task rc(input logic [6:0] i, input logic [31:0] e);
		logic [31:0] q;
		bus(i, 1'b0, 32'h0, q);
		cmp(q, e);
	endtask : rc
	// pins move one edge after the register does
	task st;
		repeat (2) @(posedge clk);
		#1;
	endtask : st
	// edge on pin 4.1 must pulse exactly three edges later, irq one after
	task edg(input logic e);
		int k;
		@(posedge clk);
		ext_lvl[3] <= ~ext_lvl[3];
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (edge_int2 !== 1'b1 && k < 8);
		cmp(k, 3);
		if (edge_int2 !== 1'b1)
			summarize;
		@(posedge clk);
		#1;
		cmp(irq, e);
		cmp(edge_int2, 1'b0);
		rc(`GPCFG_IDX_STATUS, 32'h20);
		wr(`GPCFG_IDX_STATUS, 32'h20);
	endtask : edg
	// ==========
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 5; i++)
			rc(7'(`GPCFG_IDX_P36 + i), 32'h01);
		cmp(pin_oe_n, 5'h1f);
		cmp({hresp, irq}, 2'b00);
		rc(`GPCFG_IDX_MASK, 32'h0);
		rc(`GPCFG_IDX_STATUS, 32'h0);
		rc(`GPCFG_IDX_OUTD, 32'h0);
		for (int i = 0; i < 5; i++) begin
			r = $random(seed);
			wr(7'(`GPCFG_IDX_P36 + i), r);
			rc(7'(`GPCFG_IDX_P36 + i), cfg_exp(i, r));
		end
		rc(7'h7f, 32'h0);
		for (int k = 0; k < 4; k++) begin
			m = {k[1], 5'h0, k[0], 1'b0};
			r = $random(seed);
			wr(`GPCFG_IDX_OUTD, r);
			for (int i = 0; i < 5; i++)
				wr(7'(`GPCFG_IDX_P36 + i), m);
			st;
			for (int i = 0; i < 5; i++) begin
				cmp(pin_w[i], r[i] ^ (i < 4 && m[1]));
				cmp(pin_oe_n[i], (i < 4 && m[7]) & (r[i] ^ (i < 4 && m[1])));
			end
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			alt <= 4'($random(seed));
			for (int i = 0; i < 4; i++)
				wr(7'(`GPCFG_IDX_P36 + i), 8'h04 | (k << 1));
			st;
			for (int i = 0; i < 4; i++)
				cmp(pin_w[i], alt[i] ^ k[0]);
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			ext_en <= 5'h1f;
			ext_lvl <= 5'($random(seed));
			for (int i = 0; i < 5; i++)
				wr(7'(`GPCFG_IDX_P36 + i), 8'h01 | (k << 1));
			repeat (6) @(posedge clk);
			rc(`GPCFG_IDX_LEVEL, ext_lvl ^ (k ? 5'h0f : 5'h00));
			cmp(pin_oe_n, 5'h1f);
		end
		// direction bit says output, yet the interrupt mode must keep the driver off
		wr(`GPCFG_IDX_P41, 8'h08);
		wr(`GPCFG_IDX_MASK, 32'h20);
		wr(`GPCFG_IDX_STATUS, 32'h3f);
		st;
		cmp(pin_oe_n[3], 1'b1);
		edg(1'b1);
		edg(1'b1);
		wr(`GPCFG_IDX_MASK, 32'h0);
		edg(1'b0);
		summarize;
	end
endmodule : gpcfg_top_tb
